// >>> verilog/srs_regs.svh
`ifndef SRS_REGS_SVH
`define SRS_REGS_SVH

// Clock period in nanoseconds (10 MHz).
`define SRS_CLK_PERIOD_NS 100
// Power-on reset hold, typical and shortest, in microseconds.
`define SRS_POR_TYP_US 3000
`define SRS_POR_MIN_US 1500
// Delay from reset release to clock request, in microseconds.
`define SRS_CLKREQ_US 120
// Least sleep after clock request, in nanoseconds.
`define SRS_SLEEP_NS 4200000
`define SRS_POR_TYP_CYC ((`SRS_POR_TYP_US * 1000) / `SRS_CLK_PERIOD_NS)
`define SRS_CLKREQ_CYC ((`SRS_CLKREQ_US * 1000) / `SRS_CLK_PERIOD_NS)
`define SRS_SLEEP_CYC ((`SRS_SLEEP_NS + `SRS_CLK_PERIOD_NS - 1) / `SRS_CLK_PERIOD_NS)
// Low-power clock detection window and needed edge count.
`define SRS_LPC_WIN_CYC 1000
`define SRS_LPC_MIN_EDGES 4
`define SRS_CNT_W 16

`endif

// >>> verilog/srs_pkg.sv
package srs_pkg;
	typedef enum logic [2:0] {
		SRS_RESET = 3'b000,
		SRS_WAIT_REQ = 3'b001,
		SRS_SLEEP = 3'b010,
		SRS_RUN = 3'b011
	} srs_state_t;
endpackage : srs_pkg

// >>> verilog/srs_sync3.sv
`timescale 1ns/1ps
// Three-stage synchroniser; a change is taken once stages two and three agree.
module srs_sync3 #(
	parameter logic RST_VAL = 1'b0
) (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic d_i,
	output logic q_o
);
	logic s1_ff;
	logic s2_ff;
	logic s3_ff;
	logic q_ff;

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1_ff <= RST_VAL;
			s2_ff <= RST_VAL;
			s3_ff <= RST_VAL;
		end else begin
			s1_ff <= d_i;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q_ff <= RST_VAL;
		end else if (s2_ff == s3_ff) begin
			q_ff <= s3_ff;
		end
	end

	assign q_o = q_ff;
endmodule : srs_sync3

// >>> verilog/srs_startup_seq.sv
`timescale 1ns/1ps
`include "srs_regs.svh"
// What this block does
// - Global reset combines external and power-on reset.
// - Release follows whichever source deasserts last.
// - Power-on reset holds about 3 ms.
// - Held external reset blocks startup and boot.
// - Without external reset, start after power-on.
// - Assert clock request about 120 us later.
// - Sleep at least 4.2 ms after request.
// - Missing low-power clock selects internal one.
// - No reference oscillator means crystal reference.
module srs_startup_seq #(
	parameter int POR_CYC = `SRS_POR_TYP_CYC,
	parameter int SLEEP_CYC = `SRS_SLEEP_CYC
) (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic ext_rst_n_i,
	input wire logic low_power_clock_input_i,
	input wire logic ext_ref_osc_present_i,
	output logic global_rst_n_o,
	output logic clk_req_o,
	output logic sleep_o,
	output logic boot_en_o,
	output logic use_int_lpc_o,
	output logic use_crystal_o
);
	// ****************************************************************
	// Reset sources
	// ****************************************************************
	logic ext_rst_n_s;
	logic lpc_s;
	logic ref_s;
	logic [31:0] por_cnt_ff;
	logic por_done_ff;
	logic global_rst_n_ff;

	srs_sync3 #(.RST_VAL(1'b0)) u_ext_rst (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.d_i(ext_rst_n_i),
		.q_o(ext_rst_n_s)
	);

	srs_sync3 #(.RST_VAL(1'b0)) u_lpc (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.d_i(low_power_clock_input_i),
		.q_o(lpc_s)
	);

	srs_sync3 #(.RST_VAL(1'b0)) u_ref (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.d_i(ext_ref_osc_present_i),
		.q_o(ref_s)
	);

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			por_cnt_ff <= 32'h0;
			por_done_ff <= 1'b0;
		end else if (!por_done_ff) begin
			if (por_cnt_ff >= 32'(POR_CYC - 1)) begin
				por_done_ff <= 1'b1;
			end else begin
				por_cnt_ff <= por_cnt_ff + 32'h1;
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			global_rst_n_ff <= 1'b0;
		end else begin
			global_rst_n_ff <= ext_rst_n_s & por_done_ff;
		end
	end

	assign global_rst_n_o = global_rst_n_ff;

	// ****************************************************************
	// Startup sequence
	// ****************************************************************
	srs_pkg::srs_state_t state_ff;
	srs_pkg::srs_state_t nxt_state;
	logic [31:0] seq_cnt_ff;
	logic seq_done;

	always_comb begin
		seq_done = 1'b0;
		case (state_ff)
			srs_pkg::SRS_WAIT_REQ: seq_done = (seq_cnt_ff >= 32'(`SRS_CLKREQ_CYC - 1));
			srs_pkg::SRS_SLEEP: seq_done = (seq_cnt_ff >= 32'(SLEEP_CYC - 1));
			default: seq_done = 1'b0;
		endcase
	end

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			// hold off, same path after power-on
			srs_pkg::SRS_RESET: begin
				if (global_rst_n_ff) begin
					nxt_state = srs_pkg::SRS_WAIT_REQ;
				end
			end
			srs_pkg::SRS_WAIT_REQ: begin
				if (seq_done) begin
					nxt_state = srs_pkg::SRS_SLEEP;
				end
			end
			srs_pkg::SRS_SLEEP: begin
				if (seq_done) begin
					nxt_state = srs_pkg::SRS_RUN;
				end
			end
			srs_pkg::SRS_RUN: nxt_state = srs_pkg::SRS_RUN;
			default: nxt_state = srs_pkg::SRS_RESET;
		endcase
		// A fresh external reset restarts the whole sequence.
		if (!global_rst_n_ff) begin
			nxt_state = srs_pkg::SRS_RESET;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_ff <= srs_pkg::SRS_RESET;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			seq_cnt_ff <= 32'h0;
		end else if (nxt_state != state_ff) begin
			seq_cnt_ff <= 32'h0;
		end else begin
			seq_cnt_ff <= seq_cnt_ff + 32'h1;
		end
	end

	logic clk_req_ff;
	logic sleep_ff;
	logic boot_ff;

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			clk_req_ff <= 1'b0;
			sleep_ff <= 1'b0;
			boot_ff <= 1'b0;
		end else begin
			clk_req_ff <= (nxt_state == srs_pkg::SRS_SLEEP) || (nxt_state == srs_pkg::SRS_RUN);
			sleep_ff <= (nxt_state == srs_pkg::SRS_SLEEP);
			boot_ff <= (nxt_state == srs_pkg::SRS_RUN);
		end
	end

	assign clk_req_o = clk_req_ff;
	assign sleep_o = sleep_ff;
	assign boot_en_o = boot_ff;

	// ****************************************************************
	// Clock source selection
	// ****************************************************************
	// The detector samples at the end of sleep, when the other party's clocks
	// must already be stable; a clock with fewer than 4 rising edges in the window is missed.
	logic [`SRS_CNT_W-1:0] win_cnt_ff;
	logic [3:0] edge_cnt_ff;
	logic lpc_d_ff;
	logic int_lpc_ff;
	logic crystal_ff;

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lpc_d_ff <= 1'b0;
		end else begin
			lpc_d_ff <= lpc_s;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			win_cnt_ff <= '0;
			edge_cnt_ff <= 4'h0;
		end else if (state_ff != srs_pkg::SRS_SLEEP) begin
			win_cnt_ff <= '0;
			edge_cnt_ff <= 4'h0;
		end else begin
			win_cnt_ff <= (win_cnt_ff == `SRS_CNT_W'(`SRS_LPC_WIN_CYC - 1)) ? '0 :
				win_cnt_ff + `SRS_CNT_W'(1);
			if (win_cnt_ff == `SRS_CNT_W'(`SRS_LPC_WIN_CYC - 1)) begin
				edge_cnt_ff <= 4'h0;
			end else if (lpc_s && !lpc_d_ff && edge_cnt_ff != 4'hf) begin
				edge_cnt_ff <= edge_cnt_ff + 4'h1;
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			int_lpc_ff <= 1'b0;
			crystal_ff <= 1'b0;
		end else if (state_ff == srs_pkg::SRS_SLEEP && nxt_state == srs_pkg::SRS_RUN) begin
			int_lpc_ff <= (edge_cnt_ff < 4'(`SRS_LPC_MIN_EDGES));
			crystal_ff <= !ref_s;
		end
	end

	assign use_int_lpc_o = int_lpc_ff;
	assign use_crystal_o = crystal_ff;
endmodule : srs_startup_seq

// >>> bench/srs_startup_seq_asserts.sv
`timescale 1ns/1ps
module srs_chk #(
	parameter int POR_CYC = 20,
	parameter int SLEEP_CYC = 50
) (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic ext_rst_n_i,
	input wire logic low_power_clock_input_i,
	input wire logic ext_ref_osc_present_i,
	input wire logic global_rst_n_o,
	input wire logic clk_req_o,
	input wire logic sleep_o,
	input wire logic boot_en_o,
	input wire logic use_int_lpc_o,
	input wire logic use_crystal_o
);
	int por_q;
	int req_q;
	int slp_q;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	// Counters give the delays a measurable figure.
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			por_q <= 0;
			req_q <= 0;
			slp_q <= 0;
		end else begin
			por_q <= por_q + 1;
			req_q <= global_rst_n_o ? req_q + 1 : 0;
			slp_q <= sleep_o ? slp_q + 1 : 0;
		end
	end
	sequence s_rel; $rose(global_rst_n_o); endsequence
	property p_pull; $fell(ext_rst_n_i) |-> ##[1:6] !global_rst_n_o; endproperty
	a_pull: assert property (p_pull) else $error("reset not pulled");
	property p_quiet; !global_rst_n_o [*2] |-> !(clk_req_o | sleep_o | boot_en_o); endproperty
	a_quiet: assert property (p_quiet) else $error("active in reset");
	property p_rel; s_rel |-> por_q >= POR_CYC - 1 && $past(ext_rst_n_i, 3); endproperty
	a_rel: assert property (p_rel) else $error("early release");
	property p_early; s_rel |-> !clk_req_o [*8]; endproperty
	a_early: assert property (p_early) else $error("request too soon");
	property p_req; $rose(clk_req_o) |-> req_q > 1194 && req_q < 1206; endproperty
	a_req: assert property (p_req) else $error("request delay");
	property p_slp; $rose(clk_req_o) |-> sleep_o && !boot_en_o; endproperty
	a_slp: assert property (p_slp) else $error("no sleep");
	property p_boot;
		$rose(boot_en_o) |-> !sleep_o && slp_q > SLEEP_CYC - 4 && slp_q < SLEEP_CYC + 3;
	endproperty
	a_boot: assert property (p_boot) else $error("sleep length");
	property p_sel; $changed({use_int_lpc_o, use_crystal_o}) |-> $rose(boot_en_o); endproperty
	a_sel: assert property (p_sel) else $error("selection moved");
endmodule : srs_chk
bind srs_startup_seq srs_chk #(.POR_CYC(POR_CYC), .SLEEP_CYC(SLEEP_CYC)) u_srs_chk (.*);

// >>> bench/srs_far_model.sv
`timescale 1ns/1ps
module srs_far_model (
	input wire logic sys_clk_i,
	input wire logic hold_i,
	input wire logic lpc_on_i,
	input wire logic osc_on_i,
	output logic ext_rst_n_o,
	output logic lpc_o,
	output logic osc_o
);
	logic [1:0] div_q = 2'h0;
	logic lpc_q = 1'h0;
	assign ext_rst_n_o = !hold_i;
	assign osc_o = osc_on_i;
	// The clock must be slower than half the system clock: one that toggles every cycle
	// never passes the input filter, which waits for two stages to agree.
	// clock runs early
	always @(negedge sys_clk_i) begin
		div_q <= div_q + 2'h1;
		if (!lpc_on_i) begin
			lpc_q <= 1'h0;
		end else if (div_q == 2'h3) begin
			lpc_q <= !lpc_q;
		end
	end
	assign lpc_o = lpc_q;
endmodule : srs_far_model

// >>> bench/srs_startup_seq_bench.sv
`timescale 1ns/1ps
module srs_startup_seq_bench;
	localparam int POR = 20;
	localparam int SLP = 50;
	logic sys_clk_i = 1'h0;
	logic rst_n_i = 1'h0;
	logic hold = 1'h0;
	logic lpc_on = 1'h0;
	logic osc_on = 1'h0;
	logic ext_n, lpc, osc, g, req, slp, boot, il, cr;
	logic [15:0] seed = 16'h8e46;
	logic exp_q[$];
	int num_errors = 0;
	int tests_run = 0;
	int n;
	always #50 sys_clk_i = ~sys_clk_i;
	function automatic logic [15:0] xorshift(input logic [15:0] v);
		logic [15:0] r;
		r = v ^ (v << 7);
		r = r ^ (r >> 9);
		r = r ^ (r << 8);
		return r;
	endfunction : xorshift
	srs_far_model u_srs_far_model (.sys_clk_i(sys_clk_i), .hold_i(hold), .lpc_on_i(lpc_on),
		.osc_on_i(osc_on), .ext_rst_n_o(ext_n), .lpc_o(lpc), .osc_o(osc));
	srs_startup_seq #(.POR_CYC(POR), .SLEEP_CYC(SLP)) u_srs_startup_seq (.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i), .ext_rst_n_i(ext_n), .low_power_clock_input_i(lpc),
		.ext_ref_osc_present_i(osc), .global_rst_n_o(g), .clk_req_o(req), .sleep_o(slp),
		.boot_en_o(boot), .use_int_lpc_o(il), .use_crystal_o(cr));
	task conclude();
		if (num_errors == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : conclude
	task chk(input string nm, input logic e, input logic s);
		tests_run++;
		if (s !== e) begin
			num_errors++;
			$display("mismatch %s expected %b seen %b", nm, e, s);
		end
	endtask : chk
	// Counts cycles until the chosen output rises; a hang counts as an error.
	task wt(input int k);
		n = 0;
		while ((k == 0 ? g : k == 1 ? req : boot) !== 1'h1) begin
			@(negedge sys_clk_i);
			n++;
			if (n > 1400) begin
				num_errors++;
				conclude();
			end
		end
	endtask : wt
	initial begin
		repeat (4) @(negedge sys_clk_i);
		rst_n_i = 1'h1;
		for (int i = 0; i < 5; i++) begin
			seed = xorshift(seed);
			lpc_on = seed[0];
			osc_on = i[0];
			exp_q.push_back(!seed[0]);
			exp_q.push_back(!i[0]);
			if (i > 0) begin
				hold = 1'h1;
				repeat (6 + seed[3:0]) @(negedge sys_clk_i);
				chk("held", 1'h0, g | req | boot);
				hold = 1'h0;
			end
			wt(0);
			chk("release", 1'h1, n >= (i ? 3 : POR - 1) && n <= (i ? 6 : POR + 3));
			wt(1);
			chk("req_delay", 1'h1, n >= 1195 && n <= 1205);
			chk("sleep", 1'h1, slp);
			wt(2);
			chk("boot_delay", 1'h1, n >= SLP - 2 && n <= SLP + 2);
			chk("int_lpc", exp_q.pop_front(), il);
			chk("crystal", exp_q.pop_front(), cr);
		end
		// Abort in mid-sleep must drop global reset, clock request, sleep and boot.
		hold = 1'h1;
		repeat (8) @(negedge sys_clk_i);
		hold = 1'h0;
		wt(1);
		repeat (10) @(negedge sys_clk_i);
		hold = 1'h1;
		repeat (8) @(negedge sys_clk_i);
		chk("abort", 1'h0, g | req | slp | boot);
		// A second power-on reset clears everything and reruns the full hold.
		rst_n_i = 1'h0;
		@(negedge sys_clk_i);
		chk("por_clear", 1'h0, g | req | slp | boot | il | cr);
		repeat (3) @(negedge sys_clk_i);
		rst_n_i = 1'h1;
		hold = 1'h0;
		wt(0);
		chk("por_release", 1'h1, n >= POR - 1 && n <= POR + 3);
		conclude();
	end
endmodule : srs_startup_seq_bench
